// ===== core/rch_pkg.sv
// Constants and types shared by the remote-control handshake block
// How it works
// - Standard and bank modes raise link_present within 8 s of power on.
// - Simple mode raises link_present within 15 s of power on.
// - Every mode drops link_present within 1 s of power off.
// - Standard mode raises busy no sooner than 50 ms after command fall.
// - Pass or error drops no sooner than 50 ms after clear falls.
// - Bank mode raises busy no sooner than 100 ms after command fall.
// - Simple mode busy delay: 5 ms after area change, otherwise 50 ms.
package rch_pkg;

  // Clock and tick timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_TIME_NS  = 1000000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W    = 16;

  // Delays in milliseconds, as counted in ticks
  localparam logic [15:0] BOOT_MAX_STD_MS  = 16'h1F40; // 8000 ms
  localparam logic [15:0] BOOT_MAX_SMP_MS  = 16'h3A98; // 15000 ms
  localparam logic [15:0] BOOT_MS_DEFAULT  = 16'h07D0; // 2000 ms, under both limits
  localparam logic [15:0] SETTLE_MS        = 16'h0001;
  localparam logic [15:0] BUSY_STD_MS      = 16'h0032; // 50 ms
  localparam logic [15:0] BUSY_BANK_MS     = 16'h0064; // 100 ms
  localparam logic [15:0] BUSY_SMP_CHG_MS  = 16'h0005; // 5 ms
  localparam logic [15:0] BUSY_SMP_SAME_MS = 16'h0032; // 50 ms
  localparam logic [15:0] CLEAR_DROP_MS    = 16'h0032; // 50 ms

  // Mode codes on mode_in
  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_BANK     = 2'h1;
  localparam logic [1:0] MODE_SIMPLE   = 2'h2;

  // Command kinds on op_kind_out
  localparam logic [1:0] KIND_VERIFY = 2'h0;
  localparam logic [1:0] KIND_START  = 2'h1;
  localparam logic [1:0] KIND_ENTER  = 2'h2;

  // Reset values
  localparam logic [2:0] AREA_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_BOOT,
    ST_SETTLE,
    ST_IDLE,
    ST_PRE_BUSY,
    ST_BUSY,
    ST_RESULT,
    ST_POST_CLEAR
  } rch_state_e;

endpackage

// ===== core/rch_remote_port.sv
// Remote-control connector sequencer: link, command capture, busy and result
module rch_remote_port
  import rch_pkg::*;
#(
  parameter int unsigned TICK_DIV  = TICK_CYCLES,
  parameter logic [15:0] BOOT_MS   = BOOT_MS_DEFAULT
)(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       power_on_in,
  input  wire logic       cancel_n_in,
  input  wire logic       enter_n_in,
  input  wire logic       next_n_in,
  input  wire logic       verify_request_n_in,
  input  wire logic       start_n_in,
  input  wire logic       clear_n_in,
  input  wire logic       bank_select_0_n_in,
  input  wire logic       bank_select_1_n_in,
  input  wire logic       bank_select_2_n_in,
  input  wire logic       op_done_in,
  input  wire logic       op_pass_in,
  output logic            link_present_out,
  output logic            busy_out,
  output logic            pass_out,
  output logic            error_out,
  output logic            op_start_out,
  output logic [1:0]      op_kind_out,
  output logic [2:0]      area_out,
  output logic            cancel_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick

  rch_tick_if tick_if ();

  rch_tick_gen #(
    .DIV_CYCLES (TICK_DIV)
  ) i_rch_tick_gen (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tick_if  (tick_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Falling-edge capture of the active-low inputs

  localparam int unsigned N_IN = 9;

  logic [N_IN-1:0] pins;
  logic [N_IN-1:0] prev_r;
  logic [N_IN-1:0] prev_nxt;
  logic [N_IN-1:0] fall;

  // Pin order: cancel, enter, next, verify, start, clear, bank_select_0..2
  assign pins = {bank_select_2_n_in, bank_select_1_n_in, bank_select_0_n_in,
                 clear_n_in, start_n_in, verify_request_n_in,
                 next_n_in, enter_n_in, cancel_n_in};

  always_comb
  begin
    prev_nxt = pins;
    fall     = prev_r & ~pins;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      prev_r <= '1;
    else
      prev_r <= prev_nxt;
  end

  logic f_cancel;
  logic f_enter;
  logic f_next;
  logic f_verify;
  logic f_start;
  logic f_clear;
  logic [2:0] f_bank;

  assign f_cancel = fall[0];
  assign f_enter  = fall[1];
  assign f_next   = fall[2];
  assign f_verify = fall[3];
  assign f_start  = fall[4];
  assign f_clear  = fall[5];
  assign f_bank   = fall[8:6];

  ////////////////////////////////////////////////////////////////////////////
  // Delay before busy, chosen by mode and area change

  function automatic logic [15:0] busy_delay(input logic [1:0] mode,
                                             input logic       changed);
    logic [15:0] d;
    d = BUSY_STD_MS;
    if (mode == MODE_BANK)
      d = BUSY_BANK_MS;
    else if (mode == MODE_SIMPLE)
      d = changed ? BUSY_SMP_CHG_MS : BUSY_SMP_SAME_MS;
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  rch_state_e  state_r;
  rch_state_e  state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] target_r;
  logic [15:0] target_nxt;
  logic        link_r;
  logic        link_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        pass_r;
  logic        pass_nxt;
  logic        err_r;
  logic        err_nxt;
  logic        start_r;
  logic        start_nxt;
  logic [1:0]  kind_r;
  logic [1:0]  kind_nxt;
  logic [2:0]  area_r;
  logic [2:0]  area_nxt;
  logic        changed_r;
  logic        changed_nxt;
  logic        cancel_r;
  logic        cancel_nxt;
  logic        cmd;
  logic        tick;

  assign tick = tick_if.tick;
  assign cmd  = f_verify | f_start | f_enter;

  // Next state of the whole handshake; counts elapse in whole ticks,
  // one extra tick guards the free-running phase so minimums hold.
  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = tick ? cnt_r + 16'h0001 : cnt_r;
    target_nxt  = target_r;
    link_nxt    = link_r;
    busy_nxt    = busy_r;
    pass_nxt    = pass_r;
    err_nxt     = err_r;
    start_nxt   = 1'b0;
    kind_nxt    = kind_r;
    area_nxt    = area_r;
    changed_nxt = changed_r;
    cancel_nxt  = 1'b0;
    case (state_r)
      ST_OFF:
      begin
        cnt_nxt = '0;
        if (power_on_in)
          state_nxt = ST_BOOT;
      end
      ST_BOOT:
      begin
        if (cnt_r >= BOOT_MS)
        begin
          link_nxt  = 1'b1;
          cnt_nxt   = '0;
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        if (cnt_r > SETTLE_MS)
          state_nxt = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (mode_in == MODE_BANK && f_bank != 3'h0)
        begin
          area_nxt = f_bank[0] ? 3'h0 : (f_bank[1] ? 3'h1 : 3'h2);
          changed_nxt = 1'b1;
        end
        else if (mode_in == MODE_SIMPLE && f_next)
        begin
          area_nxt    = area_r + 3'h1;
          changed_nxt = 1'b1;
        end
        else if (cmd)
        begin
          kind_nxt   = f_verify ? KIND_VERIFY : (f_start ? KIND_START : KIND_ENTER);
          target_nxt = busy_delay(mode_in, changed_r);
          cnt_nxt    = '0;
          state_nxt  = ST_PRE_BUSY;
        end
      end
      ST_PRE_BUSY:
      begin
        if (f_cancel)
          state_nxt = ST_IDLE;
        else if (cnt_r > target_r)
        begin
          busy_nxt    = 1'b1;
          start_nxt   = 1'b1;
          changed_nxt = 1'b0;
          state_nxt   = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        cancel_nxt = f_cancel;
        if (op_done_in)
        begin
          busy_nxt  = 1'b0;
          pass_nxt  = op_pass_in;
          err_nxt   = !op_pass_in;
          state_nxt = ST_RESULT;
        end
      end
      ST_RESULT:
      begin
        if (f_clear)
        begin
          cnt_nxt   = '0;
          state_nxt = ST_POST_CLEAR;
        end
      end
      ST_POST_CLEAR:
      begin
        if (cnt_r > CLEAR_DROP_MS)
        begin
          pass_nxt  = 1'b0;
          err_nxt   = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default:
        state_nxt = ST_OFF;
    endcase
    if (!power_on_in)
    begin
      state_nxt   = ST_OFF;
      link_nxt    = 1'b0;
      busy_nxt    = 1'b0;
      pass_nxt    = 1'b0;
      err_nxt     = 1'b0;
      start_nxt   = 1'b0;
      cancel_nxt  = 1'b0;
      changed_nxt = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r   <= ST_OFF;
      cnt_r     <= '0;
      target_r  <= '0;
      link_r    <= 1'b0;
      busy_r    <= 1'b0;
      pass_r    <= 1'b0;
      err_r     <= 1'b0;
      start_r   <= 1'b0;
      kind_r    <= KIND_VERIFY;
      area_r    <= AREA_RESET;
      changed_r <= 1'b0;
      cancel_r  <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      target_r  <= target_nxt;
      link_r    <= link_nxt;
      busy_r    <= busy_nxt;
      pass_r    <= pass_nxt;
      err_r     <= err_nxt;
      start_r   <= start_nxt;
      kind_r    <= kind_nxt;
      area_r    <= area_nxt;
      changed_r <= changed_nxt;
      cancel_r  <= cancel_nxt;
    end
  end

  // Outputs straight from flops
  assign link_present_out = link_r;
  assign busy_out         = busy_r;
  assign pass_out         = pass_r;
  assign error_out        = err_r;
  assign op_start_out     = start_r;
  assign op_kind_out      = kind_r;
  assign area_out         = area_r;
  assign cancel_out       = cancel_r;

endmodule // rch_remote_port

// ===== core/rch_tick_gen.sv
// Free-running divider that makes a one-cycle millisecond tick
module rch_tick_gen
  import rch_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = TICK_CYCLES
)(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  rch_tick_if.src   tick_if
);

  logic [TICK_CNT_W-1:0] div_r;
  logic [TICK_CNT_W-1:0] div_nxt;
  logic                  tick_r;
  logic                  tick_nxt;

  // Divider next state: wrap and pulse once per period
  // ms tick
  always_comb
  begin
    if (div_r == TICK_CNT_W'(DIV_CYCLES - 1))
    begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
    else
    begin
      div_nxt  = div_r + TICK_CNT_W'(1);
      tick_nxt = 1'b0;
    end
  end

  // Divider registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_if.tick = tick_r;

endmodule // rch_tick_gen

// ===== core/rch_tick_if.sv
// Millisecond tick carried from the divider to the sequencer
interface rch_tick_if;
  logic tick;

  modport src (output tick);
  modport snk (input  tick);
endinterface

// ===== dv/rch_remote_checker.sv
// Port-level timing checks for the remote-control handshake
module rch_remote_checker
  import rch_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter logic [15:0] BOOT_MS  = BOOT_MS_DEFAULT
)(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [1:0] mode_in,
  input wire logic       power_on_in,
  input wire logic       verify_request_n_in,
  input wire logic       start_n_in,
  input wire logic       enter_n_in,
  input wire logic       clear_n_in,
  input wire logic       op_done_in,
  input wire logic       op_pass_in,
  input wire logic       link_present_out,
  input wire logic       busy_out,
  input wire logic       pass_out,
  input wire logic       error_out,
  input wire logic       op_start_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned BOOT_LIM = (BOOT_MS + 2) * TICK_DIV + 4;
  int unsigned cmd_cnt_r;
  int unsigned clr_cnt_r;
  int unsigned pw_cnt_r;
  int unsigned busy_min;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since last command fall, last clear fall and power on
  always_ff @(posedge clk_in)
  begin
    cmd_cnt_r <= ($fell(verify_request_n_in) || $fell(start_n_in) || $fell(enter_n_in))
                 ? 0 : cmd_cnt_r + 1;
    clr_cnt_r <= $fell(clear_n_in) ? 0 : clr_cnt_r + 1;
    pw_cnt_r  <= (power_on_in && rst_n_in) ? pw_cnt_r + 1 : 0;
  end

  // Shortest allowed command-to-busy time for the mode
  assign busy_min = TICK_DIV * ((mode_in == MODE_BANK) ? 100 : (mode_in == MODE_SIMPLE) ? 5 : 50);

  ////////////////////////////////////////////////////////////////////////////////
  a_link_boot_bound : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    power_on_in && !link_present_out |-> pw_cnt_r <= BOOT_LIM)
    else $error("link indicator late after power on");
  a_link_off_drop : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !power_on_in |=> !link_present_out && !busy_out && !pass_out && !error_out)
    else $error("outputs still up after power off");
  a_busy_min_delay : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(busy_out) |-> cmd_cnt_r + 1 >= busy_min)
    else $error("busy rose too soon after command");
  a_clear_min_delay : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(pass_out || error_out) && power_on_in |-> clr_cnt_r + 1 >= 50 * TICK_DIV)
    else $error("result dropped too soon after clear");
  a_busy_needs_link : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    busy_out |-> link_present_out)
    else $error("busy without link");
  a_start_with_busy : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |-> op_start_out == $rose(busy_out))
    else $error("launch pulse not with busy rise");
  a_done_result : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    busy_out && op_done_in && power_on_in ##1 power_on_in |->
      !busy_out && pass_out == $past(op_pass_in) && error_out == !$past(op_pass_in))
    else $error("wrong result after operation end");
  a_result_exclusive : assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pass_out |-> !error_out)
    else $error("pass and error both high");
endmodule // rch_remote_checker

// ===== dv/rch_remote_model.sv
// Remote controller model: pulses connector pins low for the minimum width
module rch_remote_model #(
  parameter int unsigned TICK_DIV = 10
)(
  input  wire logic  clk_in,
  output logic [8:0] pins_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0]  req_r = '0;
  int unsigned hold_r [9] = '{default: 0};

  initial pins_n_out = '1;

  ////////////////////////////////////////////////////////////////////////////////
  // Hold each pin low 50 ms
  always @(posedge clk_in)
  begin
    for (int i = 0; i < 9; i++)
    begin
      if (req_r[i])
      begin
        pins_n_out[i] <= 1'b0;
        hold_r[i]     <= 50 * TICK_DIV + 1;
        req_r[i]      <= 1'b0;
      end
      else if (hold_r[i] > 1)
        hold_r[i] <= hold_r[i] - 1;
      else
        pins_n_out[i] <= 1'b1;
    end
  end

  // Request a pulse on pin i from the next edge
  task automatic press(input int i);
    req_r[i] = 1'b1;
  endtask
endmodule // rch_remote_model

// ===== dv/test_remote_control_handshake.sv
// Self-checking bench for the remote-control handshake port
module test_remote_control_handshake
  import rch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TD    = 10;       // Cycles per tick
  localparam logic [15:0] BM    = 16'h0003; // Shortened boot delay
  localparam int unsigned LIMIT = 20000;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic [1:0] mode_in = MODE_STANDARD;
  logic       power_on_in = 1'b0;
  logic       op_done_in = 1'b0;
  logic       op_pass_in = 1'b0;
  logic [8:0] pins_n;
  logic       link_present_out, busy_out, pass_out, error_out, op_start_out, cancel_out;
  logic [1:0] op_kind_out;
  logic [2:0] area_out;
  int         mismatches = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         n;

  always #50 clk_in = ~clk_in;

  rch_remote_model #(.TICK_DIV(TD)) i_rch_remote_model (.clk_in(clk_in), .pins_n_out(pins_n));

  rch_remote_port #(.TICK_DIV(TD), .BOOT_MS(BM)) i_rch_remote_port (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in), .power_on_in(power_on_in),
    .cancel_n_in(pins_n[0]), .enter_n_in(pins_n[1]), .next_n_in(pins_n[2]),
    .verify_request_n_in(pins_n[3]), .start_n_in(pins_n[4]), .clear_n_in(pins_n[5]),
    .bank_select_0_n_in(pins_n[6]), .bank_select_1_n_in(pins_n[7]),
    .bank_select_2_n_in(pins_n[8]), .op_done_in(op_done_in), .op_pass_in(op_pass_in),
    .link_present_out(link_present_out), .busy_out(busy_out), .pass_out(pass_out),
    .error_out(error_out), .op_start_out(op_start_out), .op_kind_out(op_kind_out),
    .area_out(area_out), .cancel_out(cancel_out));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Power on and wait for the link indicator
  task automatic t_boot();
    power_on_in = 1'b1;
    n = 0;
    while (link_present_out !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk(n >= BM * TD && n <= (BM + 2) * TD + 3, "link rise time");
    cyc(5 * TD);
    $display("boot test done");
  endtask

  // Area pulse, then the quiet time before a command
  task automatic sel(input logic [1:0] md, input int pin, input logic [2:0] area);
    mode_in = md;
    i_rch_remote_model.press(pin);
    cyc(53 * TD);
    chk(area_out === area, "program area");
    $display("area test done");
  endtask

  // One full command, result and clear sequence
  task automatic t_op(input logic [1:0] md, input int pin, input logic ok, input int dly,
                      input logic [1:0] kind);
    mode_in = md;
    i_rch_remote_model.press(pin);
    cyc(1);
    n = 0;
    while (busy_out !== 1'b1 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    chk(n >= dly * TD && n <= (dly + 2) * TD + 3, "busy delay");
    chk(op_kind_out === kind, "operation kind");
    cyc(3);
    op_pass_in = ok;
    op_done_in = 1'b1;
    cyc(1);
    op_done_in = 1'b0;
    chk(busy_out === 1'b0 && pass_out === ok && error_out === !ok, "result flags");
    cyc(5 * TD);
    i_rch_remote_model.press(5);
    cyc(1);
    n = 0;
    while ((pass_out | error_out) !== 1'b0 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    chk(n >= 50 * TD && n <= 52 * TD + 3, "result drop delay");
    cyc(10 * TD);
    $display("operation test done");
  endtask

  // Cancel aborts a waiting command and is echoed once while busy
  task automatic t_cancel();
    mode_in = MODE_STANDARD;
    i_rch_remote_model.press(4);
    cyc(20 * TD);
    i_rch_remote_model.press(0);
    cyc(60 * TD);
    chk(busy_out === 1'b0, "busy after cancelled command");
    i_rch_remote_model.press(4);
    n = 0;
    while (busy_out !== 1'b1 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    chk(n >= 50 * TD && n <= 52 * TD + 4, "busy delay after cancel");
    i_rch_remote_model.press(0);
    n = 0;
    while (cancel_out !== 1'b1 && n < 5)
    begin
      cyc(1);
      n++;
    end
    chk(n < 5, "cancel pulse missing");
    cyc(1);
    chk(cancel_out === 1'b0 && busy_out === 1'b1, "cancel pulse width");
    $display("cancel test done");
  endtask

  // Power off drops the link; a command during the next boot is ignored
  task automatic t_off();
    power_on_in = 1'b0;
    cyc(2);
    chk(link_present_out === 1'b0 && busy_out === 1'b0, "outputs up after power off");
    power_on_in = 1'b1;
    i_rch_remote_model.press(4);
    cyc(60 * TD);
    chk(link_present_out === 1'b1 && busy_out === 1'b0 && op_start_out === 1'b0,
        "command taken while link down");
    $display("power off test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(20);
    rst_n_in = 1'b1;
    cyc(2);
    t_boot();
    t_op(MODE_STANDARD, 3, 1'b1, 50, KIND_VERIFY);
    t_op(MODE_STANDARD, 4, 1'b0, 50, KIND_START);
    sel(MODE_BANK, 7, 3'h1);
    sel(MODE_BANK, 6, 3'h0);
    sel(MODE_BANK, 8, 3'h2);
    t_op(MODE_BANK, 4, 1'b1, 100, KIND_START);
    t_op(MODE_BANK, 1, 1'b0, 100, KIND_ENTER);
    sel(MODE_SIMPLE, 2, 3'h3);
    t_op(MODE_SIMPLE, 1, 1'b1, 5, KIND_ENTER);
    t_op(MODE_SIMPLE, 3, 1'b1, 50, KIND_VERIFY);
    t_cancel();
    t_off();
    give_verdict();
  end

  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles > LIMIT)
    begin
      mismatches++;
      give_verdict();
    end
  end
endmodule // test_remote_control_handshake

bind rch_remote_port rch_remote_checker #(.TICK_DIV(TICK_DIV), .BOOT_MS(BOOT_MS))
  i_rch_remote_checker (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in), .power_on_in(power_on_in),
  .verify_request_n_in(verify_request_n_in), .start_n_in(start_n_in),
  .enter_n_in(enter_n_in), .clear_n_in(clear_n_in), .op_done_in(op_done_in),
  .op_pass_in(op_pass_in), .link_present_out(link_present_out), .busy_out(busy_out),
  .pass_out(pass_out), .error_out(error_out), .op_start_out(op_start_out));
